// ===== design/recorder_pkg.sv
// shared constants and carrier types of the seismic waveform page recorder
// assumes the sample timebase and SI front end run on the recorder clock
//
// Contract
// - with no trigger, keep overwriting the current record in the work page.
// - threshold mode triggers when SI rises above the configured threshold.
// - after a trigger, capture until 360 s are held, then commit the page.
// - on completion keep the page; new work page has the oldest trigger time (maximum mode takes the rank 10 page or an empty one).
// - threshold mode: committed page gets rank 1, all others drop one rank (code keeps a rank 10 page at rank 10).
// - on completion, update trigger time and trigger SI headers of stored pages.
// - SI still above threshold at completion makes that instant the next trigger.
// - such a follow-on record takes 360 s from the trigger, no pre-trigger part.
// - in standby, a start command begins one forced 360 s recording.
// - a repeated start command during forced recording restarts it from then.
// - lost clock data: time 00:00:00 Jan 1 2050, minor failure until set.
// - lost waveform storage: every previously recorded page becomes invalid.
// - as shipped, minor failure holds until the clock is set.
// - maximum mode triggers when SI exceeds the SI of the rank 10 page.
// - a plain trigger keeps 30 s before and 330 s after the trigger point.
package recorder_pkg;

  // ==========================================================================
  // page store layout
  localparam int         NUM_PAGES  = 11;
  localparam int         NUM_RANKED = 10;
  localparam int         PAGE_W     = 4;
  localparam int         ADDR_W     = 16;
  localparam logic [3:0] RANK_NONE  = 4'h0;
  localparam logic [3:0] RANK_TOP   = 4'h1;
  localparam logic [3:0] RANK_LOW   = 4'ha;

  // ==========================================================================
  // timing
  localparam int REC_TOTAL_S       = 360;
  localparam int PRE_TRIG_S        = 30;
  localparam int POST_TRIG_S       = 330;
  localparam int CLK_PERIOD_NS     = 100;
  localparam int SECOND_NS         = 1_000_000_000;
  localparam int SEC_CYCLES_DEF    = SECOND_NS / CLK_PERIOD_NS;
  localparam int SAMPLES_PER_S_DEF = 100;

  // time is seconds elapsed since 00:00:00 on January 1, 2050
  localparam logic [31:0] TIME_RESET = 32'h0000_0000;

  // ==========================================================================
  // types
  typedef enum logic {
    MODE_THRESHOLD,
    MODE_MAXIMUM
  } rec_mode_e;

  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
  } accel_s;

  typedef struct packed {
    logic        valid;
    logic [3:0]  rank;
    logic [31:0] trig_time;
    logic [15:0] trig_si;
    logic [15:0] start_addr;
  } page_hdr_s;

endpackage : recorder_pkg

// ===== design/page_finder.sv
// picks the page that becomes the next work page
// assumes headers of all eleven pages are presented at once, same clock
`timescale 1ns/1ps
`default_nettype none

module page_finder
  import recorder_pkg::*;
(
  input  wire page_hdr_s [NUM_PAGES-1:0] hdrs_i,
  input  wire logic [PAGE_W-1:0]         work_i,
  output logic [PAGE_W-1:0]              oldest_o,
  output logic [PAGE_W-1:0]              lowest_o,
  output logic [15:0]                    lowest_si_o
);

  // ==========================================================================
  // oldest trigger time, an empty page preferred
  always_comb begin
    logic have_free;
    logic have_any;
    logic [31:0] best_t;
    have_free = 1'b0;
    have_any  = 1'b0;
    best_t    = 32'h0000_0000;
    oldest_o  = '0;
    for (int i = 0; i < NUM_PAGES; i++) begin
      if (PAGE_W'(i) != work_i && !have_free) begin
        if (!hdrs_i[i].valid) begin
          oldest_o  = PAGE_W'(i);
          have_free = 1'b1;
        end else if (!have_any || hdrs_i[i].trig_time < best_t) begin
          oldest_o = PAGE_W'(i);
          best_t   = hdrs_i[i].trig_time;
          have_any = 1'b1;
        end
      end
    end
  end

  // ==========================================================================
  // lowest rank page and its SI, an empty page counting as zero SI
  always_comb begin
    logic have_free;
    have_free   = 1'b0;
    lowest_o    = '0;
    lowest_si_o = 16'h0000;
    for (int i = 0; i < NUM_PAGES; i++) begin
      if (PAGE_W'(i) != work_i && !have_free) begin
        if (!hdrs_i[i].valid) begin
          lowest_o    = PAGE_W'(i);
          lowest_si_o = 16'h0000;
          have_free   = 1'b1;
        end else if (hdrs_i[i].rank == RANK_LOW) begin
          lowest_o    = PAGE_W'(i);
          lowest_si_o = hdrs_i[i].trig_si;
        end
      end
    end
  end

endmodule : page_finder

`default_nettype wire

// ===== design/waveform_recorder.sv
// waveform page recorder: work page overwrite, triggers, commit and ranking
// assumes samples, SI and commands come from logic on clk_i, no crossing
`timescale 1ns/1ps
`default_nettype none

module waveform_recorder
  import recorder_pkg::*;
#(
  parameter int SAMPLES_PER_S = SAMPLES_PER_S_DEF,
  parameter int SEC_CYCLES    = SEC_CYCLES_DEF
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              sample_valid_i,
  input  wire accel_s            sample_i,
  input  wire logic [15:0]       si_value_i,
  input  wire rec_mode_e         mode_i,
  input  wire logic [15:0]       threshold_i,
  input  wire logic              standby_i,
  input  wire logic              force_start_i,
  input  wire logic              time_set_i,
  input  wire logic [31:0]       time_value_i,
  input  wire logic              clock_lost_i,
  input  wire logic              wave_lost_i,
  input  wire logic [PAGE_W-1:0] hdr_sel_i,
  output logic                   wr_en_o,
  output logic [PAGE_W-1:0]      wr_page_o,
  output logic [ADDR_W-1:0]      wr_addr_o,
  output accel_s                 wr_data_o,
  output logic [PAGE_W-1:0]      work_page_o,
  output logic                   recording_o,
  output logic                   forced_o,
  output logic                   commit_o,
  output logic [31:0]            now_time_o,
  output logic                   minor_fail_o,
  output page_hdr_s              hdr_o
);

  // ==========================================================================
  // derived sizes and elaboration checks
  localparam int TOTAL_N = REC_TOTAL_S * SAMPLES_PER_S;
  localparam logic [ADDR_W-1:0] DEPTH    = ADDR_W'(TOTAL_N);
  localparam logic [ADDR_W-1:0] PRE_N    = ADDR_W'(PRE_TRIG_S * SAMPLES_PER_S);
  localparam logic [ADDR_W-1:0] POST_N   = ADDR_W'(POST_TRIG_S * SAMPLES_PER_S);
  localparam logic [23:0]       SEC_LAST = 24'(SEC_CYCLES - 1);

  if (SAMPLES_PER_S < 1 || TOTAL_N >= (1 << ADDR_W)) begin : g_bad_rate
    $error("sample rate does not fit the page address width");
  end
  if (SEC_CYCLES < 2 || SEC_CYCLES >= (1 << 24)) begin : g_bad_sec
    $error("second divider out of range");
  end

  typedef enum logic {
    ST_IDLE,
    ST_REC
  } rec_state_e;

  rec_state_e                state;
  logic [PAGE_W-1:0]         work_page;
  logic [ADDR_W-1:0]         wr_ptr;
  logic [ADDR_W-1:0]         remain;
  logic                      forced;
  logic [31:0]               trig_time;
  logic [15:0]               trig_si;
  logic [ADDR_W-1:0]         rec_start;
  logic [31:0]               now_time;
  logic                      time_valid;
  logic [23:0]               sec_cnt;
  page_hdr_s [NUM_PAGES-1:0] hdrs;
  logic [PAGE_W-1:0]         oldest_idx;
  logic [PAGE_W-1:0]         lowest_idx;
  logic [15:0]               lowest_si;
  logic [PAGE_W-1:0]         next_work;
  logic [3:0]                next_rank;
  logic                      force_go;
  logic                      auto_hit;
  logic                      commit;
  logic                      follow;

  // ==========================================================================
  // helpers
  function automatic logic [ADDR_W-1:0] ptr_next(input logic [ADDR_W-1:0] p);
    ptr_next = (p == DEPTH - 1'b1) ? '0 : p + 1'b1;
  endfunction : ptr_next

  function automatic logic [ADDR_W-1:0] ptr_back(input logic [ADDR_W-1:0] p, input logic [ADDR_W-1:0] n);
    ptr_back = (p >= n) ? p - n : DEPTH - (n - p);
  endfunction : ptr_back

  function automatic logic trig_cond(input rec_mode_e m, input logic [15:0] si,
                                     input logic [15:0] thr, input logic [15:0] low_si);
    trig_cond = (m == MODE_THRESHOLD) ? (si > thr) : (si > low_si);
  endfunction : trig_cond

  page_finder u_finder (
    .hdrs_i      (hdrs),
    .work_i      (work_page),
    .oldest_o    (oldest_idx),
    .lowest_o    (lowest_idx),
    .lowest_si_o (lowest_si)
  );

  // ==========================================================================
  // trigger and completion decisions
  assign force_go  = standby_i && force_start_i;
  assign auto_hit  = !standby_i && trig_cond(mode_i, si_value_i, threshold_i, lowest_si);
  assign commit    = (state == ST_REC) && sample_valid_i && (remain == 16'h0001) && !force_go;
  assign follow    = commit && !forced && auto_hit;
  assign next_work = (mode_i == MODE_THRESHOLD) ? oldest_idx : lowest_idx;

  // rank of the committed page
  always_comb begin
    logic [3:0] cnt;
    cnt = 4'h0;
    for (int i = 0; i < NUM_PAGES; i++) begin
      if (PAGE_W'(i) != work_page && PAGE_W'(i) != next_work && hdrs[i].valid && hdrs[i].trig_si >= trig_si) begin
        cnt = cnt + 4'h1;
      end
    end
    next_rank = (mode_i == MODE_THRESHOLD || forced) ? RANK_TOP : cnt + 4'h1;
  end

  // ==========================================================================
  // recording sequence
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state     <= ST_IDLE;
      remain    <= '0;
      forced    <= 1'b0;
      trig_time <= TIME_RESET;
      trig_si   <= 16'h0000;
      rec_start <= '0;
    end else if (force_go) begin
      state     <= ST_REC;
      forced    <= 1'b1;
      remain    <= DEPTH;
      trig_time <= now_time;
      trig_si   <= si_value_i;
      rec_start <= wr_ptr;
    end else if (commit) begin
      forced <= 1'b0;
      if (follow) begin
        state     <= ST_REC;
        remain    <= DEPTH;
        trig_time <= now_time;
        trig_si   <= si_value_i;
        rec_start <= '0;
      end else begin
        state <= ST_IDLE;
      end
    end else if (state == ST_IDLE && sample_valid_i && auto_hit) begin
      state     <= ST_REC;
      remain    <= POST_N - 1'b1;
      trig_time <= now_time;
      trig_si   <= si_value_i;
      rec_start <= ptr_back(wr_ptr, PRE_N);
    end else if (state == ST_REC && sample_valid_i) begin
      remain <= remain - 1'b1;
    end
  end

  // ==========================================================================
  // work page and circular write pointer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      work_page <= '0;
      wr_ptr    <= '0;
    end else if (commit) begin
      work_page <= next_work;
      wr_ptr    <= '0;
    end else if (sample_valid_i) begin
      wr_ptr <= ptr_next(wr_ptr);
    end
  end

  // sample write port toward the page memory
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_en_o   <= 1'b0;
      wr_page_o <= '0;
      wr_addr_o <= '0;
      wr_data_o <= '0;
    end else begin
      wr_en_o   <= sample_valid_i;
      wr_page_o <= work_page;
      wr_addr_o <= wr_ptr;
      wr_data_o <= sample_i;
    end
  end

  // ==========================================================================
  // page headers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hdrs <= '0;
    end else if (wave_lost_i) begin
      hdrs <= '0;
    end else if (commit) begin
      for (int i = 0; i < NUM_PAGES; i++) begin
        if (PAGE_W'(i) == work_page) begin
          hdrs[i].valid      <= 1'b1;
          hdrs[i].rank       <= next_rank;
          hdrs[i].trig_time  <= trig_time;
          hdrs[i].trig_si    <= trig_si;
          hdrs[i].start_addr <= rec_start;
        end else if (PAGE_W'(i) == next_work) begin
          hdrs[i] <= '0;
        end else if (hdrs[i].valid && hdrs[i].rank >= next_rank && hdrs[i].rank < RANK_LOW) begin
          hdrs[i].rank <= hdrs[i].rank + 4'h1;
        end
      end
    end
  end

  // header read port
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hdr_o <= '0;
    end else begin
      hdr_o <= (hdr_sel_i < PAGE_W'(NUM_PAGES)) ? hdrs[hdr_sel_i] : '0;
    end
  end

  // completion pulse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      commit_o <= 1'b0;
    end else begin
      commit_o <= commit;
    end
  end

  // ==========================================================================
  // real-time clock and minor failure
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      now_time   <= TIME_RESET;
      time_valid <= 1'b0;
      sec_cnt    <= 24'h000000;
    end else if (clock_lost_i) begin
      now_time   <= TIME_RESET;
      time_valid <= 1'b0;
      sec_cnt    <= 24'h000000;
    end else if (time_set_i) begin
      now_time   <= time_value_i;
      time_valid <= 1'b1;
      sec_cnt    <= 24'h000000;
    end else if (sec_cnt == SEC_LAST) begin
      now_time <= now_time + 32'h0000_0001;
      sec_cnt  <= 24'h000000;
    end else begin
      sec_cnt <= sec_cnt + 24'h000001;
    end
  end

  assign minor_fail_o = !time_valid;
  assign now_time_o   = now_time;
  assign work_page_o  = work_page;
  assign recording_o  = (state == ST_REC);
  assign forced_o     = forced;

  // ==========================================================================
  // assertions
  a_idle_overwrite: assert property (@(posedge clk_i) disable iff (rst_i)
    state == ST_IDLE && sample_valid_i && !auto_hit && !force_go
      |=> wr_en_o && wr_page_o == $past(work_page) && work_page == $past(work_page))
    else $error("idle sample not written to the work page");

  a_thr_trigger: assert property (@(posedge clk_i) disable iff (rst_i)
    state == ST_IDLE && sample_valid_i && !standby_i && !force_go && mode_i == MODE_THRESHOLD
      && si_value_i > threshold_i |=> state == ST_REC && remain == POST_N - 1'b1)
    else $error("threshold crossing did not start a record");

  a_max_trigger: assert property (@(posedge clk_i) disable iff (rst_i)
    state == ST_IDLE && sample_valid_i && !standby_i && !force_go && mode_i == MODE_MAXIMUM
      && si_value_i <= lowest_si |=> state == ST_IDLE)
    else $error("maximum mode triggered below lowest page SI");

  a_pre_trigger: assert property (@(posedge clk_i) disable iff (rst_i)
    state == ST_IDLE && sample_valid_i && auto_hit && !force_go
      |=> rec_start == ptr_back($past(wr_ptr), PRE_N))
    else $error("record start not 30 s before trigger");

  a_new_work: assert property (@(posedge clk_i) disable iff (rst_i)
    commit |=> work_page == $past(next_work) && wr_ptr == '0 && commit_o)
    else $error("work page not moved on completion");

  a_rank_top: assert property (@(posedge clk_i) disable iff (rst_i)
    commit && mode_i == MODE_THRESHOLD && !wave_lost_i
      |=> hdrs[$past(work_page)].rank == RANK_TOP && hdrs[$past(work_page)].valid)
    else $error("committed page not ranked first");

  a_hdr_time: assert property (@(posedge clk_i) disable iff (rst_i)
    commit && !wave_lost_i |=> hdrs[$past(work_page)].trig_time == $past(trig_time)
      && hdrs[$past(work_page)].trig_si == $past(trig_si))
    else $error("header not updated on completion");

  a_follow_on: assert property (@(posedge clk_i) disable iff (rst_i)
    follow |=> state == ST_REC && remain == DEPTH && rec_start == '0 && trig_time == $past(now_time))
    else $error("follow-on record not started at completion");

  a_force_restart: assert property (@(posedge clk_i) disable iff (rst_i)
    force_go |=> forced && state == ST_REC && remain == DEPTH && rec_start == $past(wr_ptr))
    else $error("forced start did not restart the record");

  a_clock_lost: assert property (@(posedge clk_i) disable iff (rst_i)
    clock_lost_i |=> minor_fail_o && now_time_o == TIME_RESET ##1 (minor_fail_o || $past(time_set_i)))
    else $error("lost clock not reinitialised with minor failure");

  a_wave_lost: assert property (@(posedge clk_i) disable iff (rst_i)
    wave_lost_i |=> hdrs == '0)
    else $error("pages still valid after storage loss");

  a_work_empty: assert property (@(posedge clk_i) disable iff (rst_i)
    !hdrs[work_page].valid)
    else $error("work page holds a retained header");

  c_thr_commit: cover property (@(posedge clk_i) disable iff (rst_i)
    commit && mode_i == MODE_THRESHOLD);
  c_follow_on: cover property (@(posedge clk_i) disable iff (rst_i)
    follow);
  c_force_restart: cover property (@(posedge clk_i) disable iff (rst_i)
    force_go && forced);
  c_max_commit: cover property (@(posedge clk_i) disable iff (rst_i)
    commit && mode_i == MODE_MAXIMUM);

endmodule : waveform_recorder

`default_nettype wire

// ===== tb/accel_front_model.sv
// front-end model: paced acceleration samples and the SI level
// assumes it shares clk_i and rst_i with the recorder
`timescale 1ns/1ps
`default_nettype none

module accel_front_model
  import recorder_pkg::*;
#(
  parameter int GAP = 4
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [15:0] si_level_i,
  output logic             sample_valid_o,
  output accel_s           sample_o,
  output logic [15:0]      si_value_o,
  output var int           n_samp_o
);
  logic [2:0] cnt;

  // ==========================================================================
  // pacing: one sample every GAP cycles, counted when taken
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt            <= 3'h0;
      sample_valid_o <= 1'b0;
      sample_o       <= '0;
      n_samp_o       <= 0;
    end else begin
      cnt            <= (cnt == 3'(GAP - 1)) ? 3'h0 : cnt + 3'h1;
      sample_valid_o <= (cnt == 3'h0);
      n_samp_o       <= n_samp_o + (sample_valid_o ? 1 : 0);
      // idle data is inverted every cycle, never held
      if (cnt == 3'h0) begin
        sample_o <= {16'(n_samp_o * 3 + 1), 16'(n_samp_o * 5 + 2), 16'(n_samp_o * 7 + 3)};
      end else begin
        sample_o <= ~sample_o;
      end
    end
  end

  // si level passes straight through
  assign si_value_o = si_level_i;
endmodule : accel_front_model

`default_nettype wire

// ===== tb/waveform_recorder_tb.sv
// self-checking bench of the waveform page recorder
// assumes short pages: one sample a second, ten cycles a second
`timescale 1ns/1ps
`default_nettype none

module waveform_recorder_tb
  import recorder_pkg::*;
;
  logic              clk, rst, std, frc, tset, clost, wlost, recording, forced, commit, minor, wr_en, sv;
  logic [15:0]       si_lvl, si, thr;
  logic [31:0]       tval, now_t, t0;
  logic [PAGE_W-1:0] sel, work, wr_page, p1, p2, last_w;
  logic [ADDR_W-1:0] wr_addr;
  rec_mode_e         mode;
  accel_s            smp, wr_data, last_s;
  page_hdr_s         hdr, h;
  int                errors, n_checks, seed, n_samp, base, exp_addr, k;
  logic [PAGE_W-1:0] pg [11];
  logic [15:0]       sv_of [11];
  logic [10:0]       seen;

  // ==========================================================================
  // clock, partner and design
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  accel_front_model fe_u (.clk_i(clk), .rst_i(rst), .si_level_i(si_lvl), .sample_valid_o(sv),
    .sample_o(smp), .si_value_o(si), .n_samp_o(n_samp));

  waveform_recorder #(.SAMPLES_PER_S(1), .SEC_CYCLES(10)) dut_u (.clk_i(clk), .rst_i(rst),
    .sample_valid_i(sv), .sample_i(smp), .si_value_i(si), .mode_i(mode), .threshold_i(thr),
    .standby_i(std), .force_start_i(frc), .time_set_i(tset), .time_value_i(tval),
    .clock_lost_i(clost), .wave_lost_i(wlost), .hdr_sel_i(sel), .wr_en_o(wr_en),
    .wr_page_o(wr_page), .wr_addr_o(wr_addr), .wr_data_o(wr_data), .work_page_o(work),
    .recording_o(recording), .forced_o(forced), .commit_o(commit), .now_time_o(now_t),
    .minor_fail_o(minor), .hdr_o(hdr));

  // ==========================================================================
  // checking and closing
  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      errors++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : chk

  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test

  // bounded wait: what 0 for commit, 1 for recording, 2 for a sample
  task automatic wait_on(input int what, input int n);
    for (int j = 0; j < n; j++) begin
      @(negedge clk);
      if ((what == 0 && commit === 1'b1) || (what == 1 && recording === 1'b1) || (what == 2 && sv === 1'b1)) return;
    end
    errors++;
    $display("wrong value at %0t: wait ran out", $time);
    finish_test();
  endtask : wait_on

  task automatic rd_hdr(input logic [PAGE_W-1:0] p);
    @(posedge clk);
    sel <= p;
    @(posedge clk);
    @(negedge clk);
    h = hdr;
  endtask : rd_hdr

  // address n samples back from a in a 360-sample page
  function automatic logic [ADDR_W-1:0] back_addr(input int a, input int n);
    return ADDR_W'((a + REC_TOTAL_S - n) % REC_TOTAL_S);
  endfunction : back_addr

  // auto record at level v; keep leaves the SI high through the commit
  task automatic do_rec(input logic [15:0] v, input bit keep);
    @(posedge clk);
    si_lvl <= v;
    wait_on(1, 40);
    base = n_samp - 1;
    t0 = now_t;
    if (!keep) begin
      @(posedge clk);
      si_lvl <= 16'h0000;
    end
    wait_on(0, 2000);
    chk(n_samp - base == 330, "post-trigger length");
  endtask : do_rec

  // write port monitor: data, page and wrapping address
  always @(posedge clk) begin
    if (sv === 1'b1) last_s <= smp;
    last_w <= work;
    if (wr_en === 1'b1) begin
      chk(wr_data === last_s && wr_page === last_w, "written sample");
      chk(wr_addr === exp_addr[ADDR_W-1:0], "write address");
    end
    if (rst === 1'b1 || commit === 1'b1) exp_addr <= 0;
    else if (wr_en === 1'b1) exp_addr <= (exp_addr + 1) % 360;
  end

  // ==========================================================================
  // main sequence
  initial begin
    seed = 11;
    errors = 0;
    n_checks = 0;
    exp_addr = 0;
    seen = '0;
    {rst, std, frc, tset, clost, wlost} = 6'h20;
    si_lvl = 16'h0000;
    thr = 16'h0064;
    mode = MODE_THRESHOLD;
    sel = '0;
    tval = '0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk(minor === 1'b1 && work === 4'h0 && recording === 1'b0, "reset state");
    for (k = 0; k < 12; k++) begin
      rd_hdr(4'(k));
      chk(h.valid === 1'b0, "header after reset");
    end
    @(posedge clk);
    tval <= $random(seed) & 32'h7fff_ffff; // headroom, no wrap
    tset <= 1'b1;
    @(posedge clk);
    tset <= 1'b0;
    @(negedge clk);
    chk(minor === 1'b0 && (now_t === tval || now_t === tval + 32'h1), "time set");
    // SI equal to the threshold: overwrite and wrap only
    @(posedge clk);
    si_lvl <= thr;
    repeat (1500) @(negedge clk);
    chk(recording === 1'b0, "no trigger at threshold");
    // eleven records fill every page
    for (k = 0; k < 11; k++) begin
      pg[k] = work;
      sv_of[k] = 16'(32'h65 + ($random(seed) & 32'h3ff));
      chk(seen[pg[k]] === 1'b0, "fresh work page");
      seen[pg[k]] = 1'b1;
      do_rec(sv_of[k], 1'b0);
    end
    chk(work === pg[0], "oldest page reused");
    for (k = 1; k < 11; k++) begin
      rd_hdr(pg[k]);
      chk(h.valid === 1'b1 && h.rank === 4'(11 - k) && h.trig_si === sv_of[k], "rank");
      chk(k < 10 || h.trig_time === t0 || h.trig_time === t0 - 32'h1, "trigger time");
      chk(h.start_addr === back_addr(0, PRE_TRIG_S), "pre-trigger start");
    end
    rd_hdr(pg[0]);
    chk(h.valid === 1'b0, "work header");
    // maximum mode against the rank ten SI
    @(posedge clk);
    mode <= MODE_MAXIMUM;
    si_lvl <= sv_of[1];
    repeat (40) @(negedge clk);
    chk(recording === 1'b0, "SI equal to rank ten");
    do_rec(sv_of[1] + 16'h0001, 1'b0);
    chk(work === pg[1], "rank ten page reused");
    // follow-on record with the SI still high at completion
    @(posedge clk);
    mode <= MODE_THRESHOLD;
    p1 = work;
    do_rec(16'h0400, 1'b1);
    chk(recording === 1'b1, "follow-on trigger");
    base = n_samp;
    p2 = work;
    @(posedge clk);
    si_lvl <= 16'h0000;
    wait_on(0, 2000);
    chk(n_samp - base == 360, "follow-on length");
    rd_hdr(p2);
    chk(h.rank === RANK_TOP && h.trig_si === 16'h0400 && h.start_addr === 16'h0000, "follow-on header");
    rd_hdr(p1);
    chk(h.rank === 4'h2, "earlier page ranked down");
    // forced recording: refused outside standby, restarted inside
    @(posedge clk);
    frc <= 1'b1;
    @(posedge clk);
    frc <= 1'b0;
    repeat (2) @(negedge clk);
    chk(forced === 1'b0, "start outside standby");
    @(posedge clk);
    std <= 1'b1;
    si_lvl <= 16'h0800;
    repeat (40) @(negedge clk);
    chk(recording === 1'b0, "auto trigger in standby");
    p1 = work;
    for (k = 0; k < 2; k++) begin
      wait_on(2, 8);
      @(posedge clk);
      frc <= 1'b1;
      @(posedge clk);
      frc <= 1'b0;
      @(negedge clk);
      base = n_samp;
      chk(forced === 1'b1 && recording === 1'b1, "forced start");
      repeat (60) @(posedge clk);
    end
    wait_on(0, 2000);
    chk(n_samp - base == 360, "forced length");
    rd_hdr(p1);
    chk(h.valid === 1'b1 && h.rank === RANK_TOP && recording === 1'b0, "forced header");
    // lost clock wins over a time set, then lost waveform store
    @(posedge clk);
    clost <= 1'b1;
    tset <= 1'b1;
    @(posedge clk);
    clost <= 1'b0;
    tset <= 1'b0;
    @(negedge clk);
    chk(minor === 1'b1 && now_t <= 32'h1, "clock lost");
    @(posedge clk);
    wlost <= 1'b1;
    @(posedge clk);
    wlost <= 1'b0;
    for (k = 0; k < 11; k++) begin
      rd_hdr(4'(k));
      chk(h.valid === 1'b0, "header after store loss");
    end
    finish_test();
  end
endmodule : waveform_recorder_tb

`default_nettype wire
